/* src/lmcr_pkg.sv */
// constants, types and state layout of the led matrix control register bank
package lmcr_pkg;

	// register offsets
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic [7:0] ADDR_CLOCK = 8'h03;
	localparam logic [7:0] ADDR_MATRIX = 8'h04;
	localparam logic [7:0] ADDR_FRAME_SELECT = 8'h05;
	localparam logic [7:0] ADDR_ROW_FIRST = 8'h06;
	localparam logic [7:0] ADDR_ROW_LAST = 8'h17;
	localparam logic [7:0] ADDR_THRESHOLD = 8'h18;

	// reset register bit positions
	localparam int RST_BIT_SOFT = 0;
	localparam int RST_BIT_FRAME_ONE = 1;
	localparam int RST_BIT_FRAME_TWO = 2;

	// clock and current register field positions
	localparam int CLK_BIT_EXT = 0;
	localparam int CLK_BIT_CLOCK_OUTPUT_ENABLE = 1;
	localparam int CLK_BIT_OSC = 2;
	localparam int CLK_CODE_LO = 3;
	localparam int CLK_CODE_HI = 6;
	localparam int CLK_BIT_RANGE = 7;

	// matrix control field positions
	localparam int MTX_BIT_ENABLE = 0;
	localparam int MTX_MODE_LO = 1;
	localparam int MTX_MODE_HI = 2;
	localparam int MTX_BIT_GHOST = 3;

	// values after reset, and the matrix write mask
	localparam logic [7:0] CLOCK_RESET = 8'h78;
	localparam logic [7:0] MATRIX_RESET = 8'h00;
	localparam logic [7:0] THRESHOLD_RESET = 8'h00;
	localparam logic [7:0] MATRIX_WMASK = 8'h0F;

	// frame geometry: 18 rows of 8 leds each
	localparam int ROW_COUNT = 18;

	// internal oscillator against the system clock
	localparam int SYS_CLOCK_KHZ = 100000;
	localparam int INT_OSC_KHZ = 2400;
	localparam int OSC_HALF_CYCLES_RAW = SYS_CLOCK_KHZ / (2 * INT_OSC_KHZ);
	localparam int OSC_HALF_CYCLES = (OSC_HALF_CYCLES_RAW < 1) ? 1 : OSC_HALF_CYCLES_RAW;

	// matrix modes
	typedef enum logic [1:0] {
		LMCR_MODE_FRAME_ONE = 2'h0,
		LMCR_MODE_FRAME_TWO = 2'h1,
		LMCR_MODE_MELODY = 2'h2,
		LMCR_MODE_SCROLL = 2'h3
	} lmcr_mode_t;

	typedef logic [ROW_COUNT-1:0][7:0] lmcr_frame_t;

	// register access request from the serial front end
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lmcr_req_t;

	// decoded controls toward the analog and timing blocks
	typedef struct packed {
		logic range_high;
		logic [3:0] current_code;
		logic osc_run;
		logic ext_clk;
		logic clk_out;
		logic ghost;
		logic matrix_on;
		lmcr_mode_t mode;
		logic melody_active;
		logic [7:0] threshold;
		logic threshold_auto;
	} lmcr_ctrl_t;

	// whole state of the bank
	typedef struct packed {
		logic [7:0] clk_ctl;
		logic [7:0] mtx_ctl;
		logic frame_sel;
		logic [7:0] detect_threshold_field;
		logic [7:0] detect_threshold_field_eff;
		lmcr_frame_t frame_one;
		lmcr_frame_t frame_two;
		logic scroll_shows_two;
		logic [7:0] rdata;
		logic rvalid;
		logic [2:0] clock_in_out_pin_sync;
		logic clock_in_out_pin_stable;
		logic [5:0] div_cnt;
		logic osc_level;
		logic op_tick;
		logic clock_in_out_pin_oe;
		logic clock_in_out_pin_o;
		logic soft_rst;
		logic frame_one_clr;
		logic frame_two_clr;
		lmcr_ctrl_t ctrl;
		lmcr_frame_t disp;
		lmcr_frame_t melody;
	} lmcr_state_t;

endpackage

/* src/lmcr_bank.sv */
// control register bank of the 12 x 12 led matrix driver
//
// Function
// [RL1] write one clears frame two or one
// [RL2] reset bit zero performs full soft reset
// [RL3] reset bits clear themselves, never stay pending
// [RL4] bit seven picks 30 or 60 mA range
// [RL5] four-bit current code, default full scale
// [RL6] oscillator enable bit, off by default
// [RL7] matrix enable forces oscillator on
// [RL8] clock output bit drives clock on pin
// [RL9] bit zero picks internal or external clock
// [RL10] priority: external, then clock out, melody last
// [RL11] ghost prevention enable bit, off by default
// [RL12] mode field: frame1, frame2, melody, scroll
// [RL13] matrix enable bit, off by default
// [RL14] frame select steers led row writes
// [RL15] melody mode: frame two holds melody flags
// [RL16] scroll mode writes whichever frame is free
// [RL17] eighteen write-only rows of eight leds
// [RL18] melody mode displays frame one data only
// [RL19] threshold register is one-hot threshold choice
// [RL20] all-zero threshold means automatic detection
// [RL21] two threshold bits: first set wins
// [RL22] reset pin or soft reset restores defaults
// [RL23] write-only reads return zero, no effect
`timescale 1ns/1ps

module lmcr_bank #(
	parameter int OSC_HALF = lmcr_pkg::OSC_HALF_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_reset_pin_low_active,
	input wire lmcr_pkg::lmcr_req_t i_req,
	input wire logic i_clock_in_out_pin_i,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	output lmcr_pkg::lmcr_ctrl_t o_ctrl,
	output lmcr_pkg::lmcr_frame_t o_display,
	output lmcr_pkg::lmcr_frame_t o_melody,
	output logic o_clock_in_out_pin_o,
	output logic o_clock_in_out_pin_oe,
	output logic o_op_tick,
	output logic o_soft_reset,
	output logic o_frame_one_clear,
	output logic o_frame_two_clear
);

	// the divider counter is six bits wide; refuse values it cannot count
	if (OSC_HALF < 1 || OSC_HALF > 63)
	begin : g_bad_half
		$error("OSC_HALF out of range for the divider");
	end

	////////////////////////////////////////////////////////////////////////////////
	// state
	////////////////////////////////////////////////////////////////////////////////

	lmcr_pkg::lmcr_state_t s; // present state
	lmcr_pkg::lmcr_state_t next_s; // next state
	logic [4:0] row_idx; // led row addressed by the request
	logic is_row; // request hits a led row
	logic is_wr; // write request
	logic [7:0] detect_threshold_field_new; // bits newly set in threshold
	logic ext_sel; // effective external clock
	logic clk_out_eff; // effective clock output
	logic osc_run; // oscillator running
	logic [5:0] half_last; // divider terminal count

	// first set bit wins; lowest index breaks a tie in one write
	function automatic logic [7:0] lmcr_lowest(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 7; i >= 0; i--)
		begin
			if (v[i])
				r = 8'h01 << i;
		end
		return r;
	endfunction

	assign half_last = 6'(OSC_HALF - 1);

	////////////////////////////////////////////////////////////////////////////////
	// next state
	////////////////////////////////////////////////////////////////////////////////

	// one process builds the whole next state from the present one
	always_comb
	begin
		next_s = s;
		row_idx = 5'(i_req.addr - lmcr_pkg::ADDR_ROW_FIRST);
		is_wr = i_req.wr;
		is_row = (i_req.addr >= lmcr_pkg::ADDR_ROW_FIRST)
			&& (i_req.addr <= lmcr_pkg::ADDR_ROW_LAST);
		detect_threshold_field_new = 8'h00;
		ext_sel = 1'b0;
		clk_out_eff = 1'b0;
		osc_run = 1'b0;

		// pulses and read answer last one cycle only
		next_s.rvalid = 1'b0;
		next_s.rdata = 8'h00;
		next_s.soft_rst = 1'b0; // [RL3]
		next_s.frame_one_clr = 1'b0; // [RL3]
		next_s.frame_two_clr = 1'b0; // [RL3]
		next_s.op_tick = 1'b0;

		// pin synchroniser: stage one feeds stage two, stage two feeds stage three
		next_s.clock_in_out_pin_sync = {s.clock_in_out_pin_sync[1:0], i_clock_in_out_pin_i};

		// register reads; write-only and unmapped read as zero
		if (i_req.rd)
		begin
			next_s.rvalid = 1'b1;
			case (i_req.addr)
				lmcr_pkg::ADDR_CLOCK: next_s.rdata = s.clk_ctl;
				lmcr_pkg::ADDR_MATRIX: next_s.rdata = s.mtx_ctl;
				lmcr_pkg::ADDR_FRAME_SELECT: next_s.rdata = {7'h00, s.frame_sel};
				lmcr_pkg::ADDR_THRESHOLD: next_s.rdata = s.detect_threshold_field;
				default: next_s.rdata = 8'h00; // [RL23]
			endcase
		end

		// register writes
		if (is_wr)
		begin
			case (i_req.addr)
				lmcr_pkg::ADDR_RESET:
				begin
					// self-clearing triggers, nothing stored
					if (i_req.wdata[lmcr_pkg::RST_BIT_FRAME_ONE])
					begin
						next_s.frame_one = '0; // [RL1]
						next_s.frame_one_clr = 1'b1; // [RL1]
					end
					if (i_req.wdata[lmcr_pkg::RST_BIT_FRAME_TWO])
					begin
						next_s.frame_two = '0; // [RL1]
						next_s.frame_two_clr = 1'b1; // [RL1]
					end
				end
				lmcr_pkg::ADDR_CLOCK: next_s.clk_ctl = i_req.wdata; // [RL4] [RL5] [RL6] [RL8] [RL9]
				lmcr_pkg::ADDR_MATRIX:
					next_s.mtx_ctl = i_req.wdata & lmcr_pkg::MATRIX_WMASK; // [RL11] [RL12] [RL13]
				lmcr_pkg::ADDR_FRAME_SELECT: next_s.frame_sel = i_req.wdata[0];
				lmcr_pkg::ADDR_THRESHOLD:
				begin
					next_s.detect_threshold_field = i_req.wdata;
					// keep the earlier choice while its bit stays set
					detect_threshold_field_new = i_req.wdata & ~s.detect_threshold_field;
					if ((s.detect_threshold_field_eff & i_req.wdata) != 8'h00)
						next_s.detect_threshold_field_eff = s.detect_threshold_field_eff; // [RL21]
					else if (detect_threshold_field_new != 8'h00)
						next_s.detect_threshold_field_eff = lmcr_lowest(detect_threshold_field_new); // [RL21]
					else
						next_s.detect_threshold_field_eff = lmcr_lowest(i_req.wdata); // [RL19] [RL20]
				end
				default:
				begin
					if (is_row)
					begin
						// scroll ignores frame select and fills the hidden frame
						if (lmcr_pkg::lmcr_mode_t'(s.mtx_ctl[2:1]) == lmcr_pkg::LMCR_MODE_SCROLL)
						begin
							if (s.scroll_shows_two)
								next_s.frame_one[row_idx] = i_req.wdata; // [RL16]
							else
								next_s.frame_two[row_idx] = i_req.wdata; // [RL16]
							// a finished character becomes the shown one
							if (i_req.addr == lmcr_pkg::ADDR_ROW_LAST)
								next_s.scroll_shows_two = ~s.scroll_shows_two; // [RL16]
						end
						else if (s.frame_sel)
							next_s.frame_two[row_idx] = i_req.wdata; // [RL14] [RL15] [RL17]
						else
							next_s.frame_one[row_idx] = i_req.wdata; // [RL14] [RL17]
					end
				end
			endcase

			// soft reset overrides everything written above
			if (i_req.addr == lmcr_pkg::ADDR_RESET && i_req.wdata[lmcr_pkg::RST_BIT_SOFT])
			begin
				next_s.clk_ctl = lmcr_pkg::CLOCK_RESET; // [RL2] [RL22]
				next_s.mtx_ctl = lmcr_pkg::MATRIX_RESET; // [RL22]
				next_s.frame_sel = 1'b0; // [RL22]
				next_s.detect_threshold_field = lmcr_pkg::THRESHOLD_RESET; // [RL22]
				next_s.detect_threshold_field_eff = lmcr_pkg::THRESHOLD_RESET; // [RL22]
				next_s.frame_one = '0; // [RL22]
				next_s.frame_two = '0; // [RL22]
				next_s.scroll_shows_two = 1'b0;
				next_s.soft_rst = 1'b1; // [RL2]
			end
		end

		// clock source priority decided from the stored settings
		ext_sel = next_s.clk_ctl[lmcr_pkg::CLK_BIT_EXT]; // [RL9] [RL10]
		clk_out_eff = next_s.clk_ctl[lmcr_pkg::CLK_BIT_CLOCK_OUTPUT_ENABLE] && !ext_sel; // [RL8] [RL10]
		osc_run = next_s.clk_ctl[lmcr_pkg::CLK_BIT_OSC]
			|| next_s.mtx_ctl[lmcr_pkg::MTX_BIT_ENABLE]; // [RL6] [RL7]

		// decoded controls
		next_s.ctrl.range_high = next_s.clk_ctl[lmcr_pkg::CLK_BIT_RANGE]; // [RL4]
		next_s.ctrl.current_code =
			next_s.clk_ctl[lmcr_pkg::CLK_CODE_HI:lmcr_pkg::CLK_CODE_LO]; // [RL5]
		next_s.ctrl.osc_run = osc_run; // [RL7]
		next_s.ctrl.ext_clk = ext_sel;
		next_s.ctrl.clk_out = clk_out_eff;
		next_s.ctrl.ghost = next_s.mtx_ctl[lmcr_pkg::MTX_BIT_GHOST]; // [RL11]
		next_s.ctrl.matrix_on = next_s.mtx_ctl[lmcr_pkg::MTX_BIT_ENABLE]; // [RL13]
		next_s.ctrl.mode = lmcr_pkg::lmcr_mode_t'(
			next_s.mtx_ctl[lmcr_pkg::MTX_MODE_HI:lmcr_pkg::MTX_MODE_LO]); // [RL12]
		next_s.ctrl.melody_active = (next_s.ctrl.mode == lmcr_pkg::LMCR_MODE_MELODY)
			&& !ext_sel && !clk_out_eff; // [RL10]
		next_s.ctrl.threshold = next_s.detect_threshold_field_eff; // [RL19]
		next_s.ctrl.threshold_auto = (next_s.detect_threshold_field_eff == 8'h00); // [RL20]

		// displayed pattern per mode; a demoted melody shows frame one plainly
		next_s.melody = '0;
		case (next_s.ctrl.mode)
			lmcr_pkg::LMCR_MODE_FRAME_ONE: next_s.disp = next_s.frame_one; // [RL12]
			lmcr_pkg::LMCR_MODE_FRAME_TWO: next_s.disp = next_s.frame_two; // [RL12]
			lmcr_pkg::LMCR_MODE_MELODY:
			begin
				next_s.disp = next_s.frame_one; // [RL18]
				if (next_s.ctrl.melody_active)
					next_s.melody = next_s.frame_two; // [RL15]
			end
			lmcr_pkg::LMCR_MODE_SCROLL:
				next_s.disp = next_s.scroll_shows_two ? next_s.frame_two : next_s.frame_one;
			default: next_s.disp = next_s.frame_one;
		endcase
		if (!next_s.ctrl.matrix_on)
		begin
			next_s.disp = '0; // [RL13]
			next_s.melody = '0;
		end

		// internal oscillator: divider halves toggle the level
		if (osc_run)
		begin
			if (s.div_cnt >= half_last)
			begin
				next_s.div_cnt = 6'h00;
				next_s.osc_level = ~s.osc_level;
			end
			else
				next_s.div_cnt = s.div_cnt + 6'h01;
		end
		else
		begin
			// a stopped oscillator parks low so a restart begins cleanly
			next_s.div_cnt = 6'h00;
			next_s.osc_level = 1'b0;
		end

		// external edge counts once stages two and three agree
		if (s.clock_in_out_pin_sync[1] == s.clock_in_out_pin_sync[2] && s.clock_in_out_pin_sync[2] != s.clock_in_out_pin_stable)
			next_s.clock_in_out_pin_stable = s.clock_in_out_pin_sync[2];

		// operating tick from the selected source
		if (ext_sel)
			next_s.op_tick = next_s.clock_in_out_pin_stable && !s.clock_in_out_pin_stable; // [RL9]
		else
			next_s.op_tick = next_s.osc_level && !s.osc_level; // [RL9]

		// pin drives the clock only when not used as input
		next_s.clock_in_out_pin_oe = clk_out_eff; // [RL8] [RL10]
		next_s.clock_in_out_pin_o = clk_out_eff && next_s.osc_level; // [RL8]
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register
	////////////////////////////////////////////////////////////////////////////////

	// reset pin returns every register to its default
	always_ff @(posedge i_clock or negedge i_reset_pin_low_active)
	begin
		if (!i_reset_pin_low_active)
		begin
			s <= '0;
			s.clk_ctl <= lmcr_pkg::CLOCK_RESET; // [RL22]
			s.ctrl.range_high <= 1'b0;
			s.ctrl.current_code <= 4'hF; // [RL5]
			s.ctrl.threshold_auto <= 1'b1; // [RL20]
		end
		else
			s <= next_s;
	end

	// every output straight from the state register
	assign o_rdata = s.rdata;
	assign o_rvalid = s.rvalid;
	assign o_ctrl = s.ctrl;
	assign o_display = s.disp;
	assign o_melody = s.melody;
	assign o_clock_in_out_pin_o = s.clock_in_out_pin_o;
	assign o_clock_in_out_pin_oe = s.clock_in_out_pin_oe;
	assign o_op_tick = s.op_tick;
	assign o_soft_reset = s.soft_rst;
	assign o_frame_one_clear = s.frame_one_clr;
	assign o_frame_two_clear = s.frame_two_clr;

	////////////////////////////////////////////////////////////////////////////////
	// assertions
	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_reset_pin_low_active);

	// soft reset is a single pulse, with the clock defaults restored in the same cycle
	property p_soft_pulse;
		i_req.wr && i_req.addr == lmcr_pkg::ADDR_RESET && i_req.wdata[0]
		|=> o_soft_reset && o_ctrl.current_code == 4'hF && !o_ctrl.matrix_on
		##1 (!o_soft_reset
		|| $past(i_req.wr && i_req.addr == lmcr_pkg::ADDR_RESET && i_req.wdata[0]));
	endproperty
	a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset not one pulse"); // [RL2]

	// reset register never reads back a pending one
	property p_reset_reads_zero;
		i_req.rd && i_req.addr == lmcr_pkg::ADDR_RESET |=> o_rvalid && o_rdata == 8'h00;
	endproperty
	a_reset_reads_zero: assert property (p_reset_reads_zero) else $error("reset reg read"); // [RL3]

	// last row register reads as zero
	property p_row_reads_zero;
		i_req.rd && i_req.addr == lmcr_pkg::ADDR_ROW_LAST |=> o_rvalid && o_rdata == 8'h00;
	endproperty
	a_row_reads_zero: assert property (p_row_reads_zero) else $error("row read nonzero"); // [RL23]

	// frame one clear empties frame one
	property p_frame_one_clear;
		i_req.wr && i_req.addr == lmcr_pkg::ADDR_RESET && i_req.wdata[1]
		|=> s.frame_one == '0 && o_frame_one_clear;
	endproperty
	a_frame_one_clear: assert property (p_frame_one_clear) else $error("frame one kept"); // [RL1]

	// matrix enable keeps the oscillator running
	property p_osc_forced;
		o_ctrl.matrix_on |-> o_ctrl.osc_run;
	endproperty
	a_osc_forced: assert property (p_osc_forced) else $error("oscillator off with matrix"); // [RL7]

	// external clock beats clock output and melody
	property p_clock_priority;
		(o_ctrl.ext_clk |-> !o_clock_in_out_pin_oe && !o_ctrl.melody_active)
		and (o_ctrl.clk_out |-> !o_ctrl.melody_active);
	endproperty
	a_clock_priority: assert property (p_clock_priority) else $error("clock priority"); // [RL10]

	// threshold output is one-hot or automatic
	property p_threshold_onehot;
		$onehot0(o_ctrl.threshold) && (o_ctrl.threshold_auto == (o_ctrl.threshold == 8'h00));
	endproperty
	a_threshold_onehot: assert property (p_threshold_onehot) else $error("threshold code"); // [RL19]

	// a later second bit leaves the first choice in place
	property p_threshold_first;
		i_req.wr && i_req.addr == lmcr_pkg::ADDR_THRESHOLD && (s.detect_threshold_field_eff & i_req.wdata) != 8'h00
		|=> o_ctrl.threshold == $past(s.detect_threshold_field_eff);
	endproperty
	a_threshold_first: assert property (p_threshold_first) else $error("threshold changed"); // [RL21]

	// normal-mode write with select zero lands in frame one
	property p_row_to_frame_one;
		i_req.wr && i_req.addr == lmcr_pkg::ADDR_ROW_FIRST && !s.frame_sel
		&& s.mtx_ctl[2:1] == 2'h0
		|=> s.frame_one[0] == $past(i_req.wdata);
	endproperty
	a_row_to_frame_one: assert property (p_row_to_frame_one) else $error("row write lost"); // [RL14]

	// scenario coverage
	c_melody: cover property (o_ctrl.melody_active && o_ctrl.matrix_on);
	c_scroll_swap: cover property (s.scroll_shows_two ##1 !s.scroll_shows_two);
	c_ext_tick: cover property (o_ctrl.ext_clk && o_op_tick);

endmodule

/* testbench/lmcr_host.sv */
// host processor model that issues register accesses to the bank
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////
module lmcr_host (
	input wire logic i_clock,
	output lmcr_pkg::lmcr_req_t o_req
);
	// idle request until the first access
	initial o_req = '0;

	// write held across one rising edge, released at the next falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clock);
		o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge i_clock);
		o_req <= '0;
	endtask

	// read strobe, answer is picked up by the bench monitor
	task automatic rd(input logic [7:0] a);
		@(negedge i_clock);
		o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge i_clock);
		o_req <= '0;
	endtask
	// conflicting clock and threshold settings are only sent when a test asks
endmodule

/* testbench/led_matrix_control_registers_test.sv */
// self-checking bench for the led matrix control register bank
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////
module led_matrix_control_registers_test;
	logic clock;
	logic reset_pin_low_active;
	logic ext_drv;
	lmcr_pkg::lmcr_req_t req;
	logic [7:0] rdata;
	logic rvalid, clock_in_out_pin_o, clock_in_out_pin_oe, op_tick, soft_p, clr1_p, clr2_p;
	lmcr_pkg::lmcr_ctrl_t ctrl;
	lmcr_pkg::lmcr_frame_t disp, mel, f1, f2;
	logic [7:0] exp_q[$];
	logic [7:0] clk, mtx, thr, v;
	logic [7:0] ra[10] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h17, 8'h18, 8'h01, 8'h19, 8'hFF};
	logic [7:0] re[10] = '{8'h00, 8'h78, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	int num_errors, n_compared, cycles, ticks, pe, np[3];
	logic po; // last clock pin drive level seen by the monitor

	// pin level: bank drives while enabled, else the external source
	wire logic clock_in_out_pin = clock_in_out_pin_oe ? clock_in_out_pin_o : ext_drv;

	lmcr_bank #(.OSC_HALF(2)) DUT (.i_clock(clock), .i_reset_pin_low_active(reset_pin_low_active), .i_req(req),
		.i_clock_in_out_pin_i(clock_in_out_pin), .o_rdata(rdata), .o_rvalid(rvalid), .o_ctrl(ctrl),
		.o_display(disp), .o_melody(mel), .o_clock_in_out_pin_o(clock_in_out_pin_o), .o_clock_in_out_pin_oe(clock_in_out_pin_oe),
		.o_op_tick(op_tick), .o_soft_reset(soft_p), .o_frame_one_clear(clr1_p),
		.o_frame_two_clear(clr2_p));
	lmcr_host host (.i_clock(clock), .o_req(req));

	// 100 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// generic compare, wide enough for a whole frame
	task automatic cmp(input logic [143:0] got, input logic [143:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask

	// read data compare for the monitor
	task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
		cmp(144'(got), 144'(exp));
	endtask

	// verdict and end of run
	task automatic stop_test;
		if (exp_q.size() != 0)
			num_errors++;
		if (num_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// read with expected value noted for the monitor
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.rd(a);
	endtask

	task automatic settle;
		repeat (2) @(negedge clock);
	endtask

	// expected decoded controls from the register images
	task automatic chk_ctrl;
		lmcr_pkg::lmcr_ctrl_t e;
		e.range_high = clk[7];
		e.current_code = clk[6:3];
		e.osc_run = clk[2] | mtx[0];
		e.ext_clk = clk[0];
		e.clk_out = clk[1] & ~clk[0];
		e.ghost = mtx[3];
		e.matrix_on = mtx[0];
		e.mode = lmcr_pkg::lmcr_mode_t'(mtx[2:1]);
		e.melody_active = (mtx[2:1] == 2'h2) & ~clk[0] & ~clk[1];
		e.threshold = thr;
		e.threshold_auto = (thr == 8'h00);
		cmp(144'(ctrl), 144'(e));
		cmp(144'(clock_in_out_pin_oe), 144'(e.clk_out));
	endtask

	// random rows into one frame image
	task automatic rows(input int n, input bit to2);
		for (int i = 0; i < n; i++)
		begin
			v = 8'($urandom);
			host.wr(8'h06 + 8'(i), v);
			if (to2)
				f2[i] = v;
			else
				f1[i] = v;
		end
		settle();
	endtask

	// write a reset register value and count each pulse
	task automatic rst_wr(input logic [7:0] d);
		np = '{0, 0, 0};
		host.wr(8'h00, d);
		repeat (4) @(negedge clock);
		cmp(144'(np[0]), 144'(d[0]));
		cmp(144'(np[1]), 144'(d[1]));
		cmp(144'(np[2]), 144'(d[2]));
	endtask

	// count ticks and pin clock edges; cleared off the monitor's edge to avoid a race
	task automatic tick_win(input int n, input int e, input int p);
		@(posedge clock);
		ticks = 0;
		pe = 0;
		repeat (n) @(negedge clock);
		cmp(144'(ticks), 144'(e));
		cmp(144'(pe), 144'(p));
	endtask

	// monitor: read answers, pulses and ticks
	always @(negedge clock)
	begin
		if (rvalid === 1'b1 && exp_q.size() > 0)
			cmp_rd(rdata, exp_q.pop_front());
		else if (rvalid === 1'b1)
			num_errors++;
		np[0] += (soft_p === 1'b1);
		np[1] += (clr1_p === 1'b1);
		np[2] += (clr2_p === 1'b1);
		ticks += (op_tick === 1'b1);
		pe += (clock_in_out_pin_o === 1'b1 && po === 1'b0);
		po = clock_in_out_pin_o;
	end

	// hang guard
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			stop_test();
		end
	end

	// main sequence
	initial
	begin
		reset_pin_low_active = 1'b0;
		ext_drv = 1'b0;
		clk = 8'h78;
		mtx = 8'h00;
		thr = 8'h00;
		f1 = '0;
		f2 = '0;
		void'($urandom(22166));
		repeat (10) @(posedge clock);
		@(negedge clock) reset_pin_low_active = 1'b1;
		chk_ctrl();
		for (int i = 0; i < 10; i++)
			rd(ra[i], re[i]);
		// clock and current register, both range ends then random
		for (int i = 0; i < 8; i++)
		begin
			clk = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
			host.wr(8'h03, clk);
			settle();
			chk_ctrl();
			rd(8'h03, clk);
		end
		clk = 8'h78;
		host.wr(8'h03, clk);
		// every matrix mode with random ghost and high bits
		for (int m = 0; m < 4; m++)
		begin
			v = 8'($urandom);
			mtx = {v[7:3], 2'(m), 1'b1};
			host.wr(8'h04, mtx);
			settle();
			mtx = mtx & 8'h0F;
			chk_ctrl();
			rd(8'h04, mtx);
		end
		// frame one then frame two, shown by mode
		mtx = 8'h01;
		host.wr(8'h04, mtx);
		host.wr(8'h05, 8'h00);
		rows(18, 1'b0);
		cmp(disp, f1);
		host.wr(8'h05, 8'h01);
		rd(8'h05, 8'h01);
		rows(18, 1'b1);
		cmp(disp, f1);
		host.wr(8'h04, 8'h03);
		settle();
		cmp(disp, f2);
		// melody: frame two holds flags, frame one is shown
		mtx = 8'h05;
		host.wr(8'h04, mtx);
		rows(3, 1'b1);
		cmp(disp, f1);
		cmp(mel, f2);
		chk_ctrl();
		// all three clock and mode bits: melody loses
		clk = 8'h7B;
		host.wr(8'h03, clk);
		settle();
		chk_ctrl();
		cmp(mel, '0);
		cmp(disp, f1);
		clk = 8'h78;
		host.wr(8'h03, clk);
		// frame clears
		rst_wr(8'h02);
		f1 = '0;
		rst_wr(8'h04);
		f2 = '0;
		cmp(disp, f1);
		cmp(mel, f2);
		// scroll: hidden frame written, last row flips view
		mtx = 8'h07;
		host.wr(8'h04, mtx);
		host.wr(8'h05, 8'h00);
		rows(17, 1'b1);
		cmp(disp, f1);
		v = 8'($urandom);
		host.wr(8'h17, v);
		f2[17] = v;
		settle();
		cmp(disp, f2);
		// one-hot thresholds, then two bits, then automatic
		for (int b = 0; b < 8; b++)
		begin
			thr = 8'h01 << b;
			host.wr(8'h18, thr);
			settle();
			chk_ctrl();
		end
		thr = 8'h04;
		host.wr(8'h18, thr);
		host.wr(8'h18, 8'h14);
		settle();
		chk_ctrl();
		rd(8'h18, 8'h14);
		thr = 8'h00;
		host.wr(8'h18, thr);
		settle();
		chk_ctrl();
		// soft reset back to defaults
		host.wr(8'h18, 8'h02);
		rst_wr(8'h01);
		mtx = 8'h00;
		f1 = '0;
		f2 = '0;
		chk_ctrl();
		cmp(disp, '0);
		rd(8'h03, 8'h78);
		rd(8'h18, 8'h00);
		// operating clock sources
		tick_win(40, 0, 0);
		clk = 8'h7E;
		host.wr(8'h03, clk);
		settle();
		chk_ctrl();
		tick_win(40, 10, 10);
		clk = 8'h78;
		host.wr(8'h03, clk);
		mtx = 8'h01;
		host.wr(8'h04, mtx);
		settle();
		tick_win(40, 10, 0);
		mtx = 8'h00;
		host.wr(8'h04, mtx);
		clk = 8'h79;
		host.wr(8'h03, clk);
		settle();
		ticks = 0;
		for (int i = 0; i < 16; i++)
			repeat (5) @(negedge clock) ext_drv = ~i[0];
		repeat (10) @(negedge clock);
		cmp(144'(ticks), 144'(8));
		// asynchronous reset in mid-run
		reset_pin_low_active = 1'b0;
		repeat (2) @(negedge clock);
		reset_pin_low_active = 1'b1;
		clk = 8'h78;
		chk_ctrl();
		settle();
		stop_test();
	end
endmodule
